// File: pkg/swd_defs.vh
// Constants for the serial wire packet write path and its register map.
// Operation
// R1: A request begins with one start bit of value 1.
// R2: Port select bit is 0 for debug port, 1 for access port.
// R3: Direction bit is 0 for write, 1 for read.
// R4: Two address bits 3:2 follow, bit 2 first on the wire.
// R5: Debug port address 01 also uses the bank select field.
// R6: Access port address combines request bits with select register address field.
// R7: One parity bit follows the address bits.
// R8: The stop bit is always 0.
// R9: Host parks the line high; the target reads park as 1.
// R10: Acknowledge is three bits: value 001 OK, 010 WAIT, 100 FAULT.
// R11: Host sends write data as 32 bits, least significant first.
// R12: Target sends read data as 32 bits, least significant first.
// R13: A write with device ready and no error is acknowledged OK.
// R14: A write to the target selection register never gets OK.
// R15: A good write is 8 request bits, 3 ack bits, 33 data bits.
// R16: Turnarounds separate request from ack and ack from write data.
// R17: Host sends write data right after the ack and turnaround.
// R18: Debug port write is performed only after the data phase completes.
// R19: No turnaround after write data; next request may follow at once.
// R20: Request parity is even over port select, direction and address.
// R21: Write data ends with even parity over the 32 bits.
// R22: Turnaround length follows the turnaround length field, default one.
// R23: Host may idle by clocking with the data line low.
// R24: Wire order: start, port select, direction, A2, A3, parity, stop, park.
`ifndef SWD_DEFS_VH
`define SWD_DEFS_VH

`define REG_LINK_CTRL 8'h00
`define REG_SELECT 8'h04
`define REG_STATUS 8'h08
`define REG_READ_DATA 8'h0C
`define REG_LAST_WDATA 8'h10
`define REG_LAST_WADDR 8'h14

`define CTRL_TRN_LO 0
`define CTRL_TRN_HI 1
`define CTRL_FORCE_WAIT 4
`define CTRL_RST 32'h0000_0000
`define SELECT_RST 32'h0000_0000
`define READ_DATA_RST 32'h0000_0000

`define STAT_PROTO_ERR 0
`define STAT_WDATA_ERR 1

`define ACK_OK 3'h1
`define ACK_WAIT 3'h2
`define ACK_FAULT 3'h4

`define DP_A_BANKED 2'h1
`define DP_A_SELECT 2'h2
`define DP_A_TARGET_SELECTION_REGISTER 2'h3

`define REQ_BITS 6'h06
`define DATA_BITS 6'h20

`endif

// File: hdl/pin_sync.v
// Three-stage synchroniser for an outside pin with agreement filter and rise pulse.
`timescale 1ns/100ps
module pin_sync (
  input wire clk,
  input wire rst,
  input wire pin,
  output reg level_q,
  output reg rise_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // The level only moves once stages two and three agree, which rejects a lone glitch.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      rise_q <= 1'b0;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
        rise_q <= s3_q & ~level_q;
      end
    end
  end
endmodule

// File: hdl/lsb_shift_in.v
// Serial-in shift register taking least significant bit first, with running parity.
`timescale 1ns/100ps
module lsb_shift_in #(
  parameter W = 32
) (
  input wire clk,
  input wire rst,
  input wire clr,
  input wire en,
  input wire din,
  output reg [W-1:0] data_q,
  output reg par_q
);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= {W{1'b0}};
      par_q <= 1'b0;
    end else if (clr) begin
      data_q <= {W{1'b0}};
      par_q <= 1'b0;
    end else if (en) begin
      data_q <= {din, data_q[W-1:1]}; // R11
      par_q <= par_q ^ din;
    end
  end
endmodule

// File: hdl/swd_write_port.v
// Target-side serial wire packet framing with an APB register slave.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "swd_defs.vh"
module swd_write_port #(
  parameter DATA_W = 32
) (
  input wire MCLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire SWCLK,
  input wire SWDIO_IN,
  output reg SWDIO_OUT,
  output reg SWDIO_OE,
  output reg WR_VALID,
  output reg WR_AP,
  output reg [31:0] WR_ADDR,
  output reg [DATA_W-1:0] WR_DATA
);
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_REQ = 8'h02;
  localparam [7:0] S_TRN1 = 8'h04;
  localparam [7:0] S_ACK = 8'h08;
  localparam [7:0] S_RDAT = 8'h10;
  localparam [7:0] S_TRN2 = 8'h20;
  localparam [7:0] S_WDAT = 8'h40;
  localparam [7:0] S_TRNE = 8'h80;

  wire clk_rise;
  wire dio;
  wire [DATA_W-1:0] sh_data;
  wire sh_par;
  wire sh_en;
  wire sh_clr;

  reg [7:0] state_q;
  reg [5:0] bit_cnt_q;
  reg [1:0] trn_cnt_q;
  reg [4:0] req_q;
  reg [2:0] ack_q;
  reg silent_q;
  reg tsel_q;
  reg ap_q;
  reg rnw_q;
  reg [1:0] a_q;
  reg [31:0] rd_sh_q;

  reg [31:0] ctrl_q;
  reg [31:0] select_q;
  reg [31:0] read_data_q;
  reg proto_err_q;
  reg wdata_err_q;

  reg proto_set;
  reg wdata_set;
  reg sel_from_link;
  reg [31:0] rd_mux;
  reg map_ok;
  reg ro_reg;

  wire [1:0] trn_field;
  wire force_wait;
  wire apb_acc;
  wire apb_wr;
  wire [31:0] dec_addr;
  wire req_par_ok;
  wire req_frame_ok;

  pin_sync u_clk_sync (
    .clk(MCLK),
    .rst(RST),
    .pin(SWCLK),
    .level_q(),
    .rise_q(clk_rise)
  );

  // Data passes the same depth as the clock so both stay aligned at each detected edge.
  pin_sync u_dio_sync (
    .clk(MCLK),
    .rst(RST),
    .pin(SWDIO_IN),
    .level_q(dio),
    .rise_q()
  );

  assign sh_en = clk_rise & state_q[6] & (bit_cnt_q != `DATA_BITS);
  assign sh_clr = state_q[0];

  lsb_shift_in #(
    .W(DATA_W)
  ) u_wdata (
    .clk(MCLK),
    .rst(RST),
    .clr(sh_clr),
    .en(sh_en),
    .din(dio),
    .data_q(sh_data),
    .par_q(sh_par)
  );

  assign trn_field = ctrl_q[`CTRL_TRN_HI:`CTRL_TRN_LO];
  assign force_wait = ctrl_q[`CTRL_FORCE_WAIT];

  // Debug port address uses the bank only for address 01; access port uses select.
  assign dec_addr = ap_q ? {select_q[31:4], a_q, 2'h0} : // R6
    {24'h00_0000, (a_q == `DP_A_BANKED) ? select_q[3:0] : 4'h0, a_q, 2'h0}; // R5

  // Fields sit in req_q in wire order: port select, direction, A2, A3, parity; the stop bit goes to silent_q.
  assign req_par_ok = (req_q[4] == ^req_q[3:0]); // R7 R20
  assign req_frame_ok = req_par_ok & (bit_cnt_q == `REQ_BITS) & dio; // R9

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q <= S_IDLE;
      bit_cnt_q <= 6'h00;
      trn_cnt_q <= 2'h0;
      req_q <= 5'h00;
      ack_q <= 3'h0;
      silent_q <= 1'b0;
      tsel_q <= 1'b0;
      ap_q <= 1'b0;
      rnw_q <= 1'b0;
      a_q <= 2'h0;
      rd_sh_q <= 32'h0000_0000;
      SWDIO_OUT <= 1'b0;
      SWDIO_OE <= 1'b0;
      WR_VALID <= 1'b0;
      WR_AP <= 1'b0;
      WR_ADDR <= 32'h0000_0000;
      WR_DATA <= {DATA_W{1'b0}};
      proto_set <= 1'b0;
      wdata_set <= 1'b0;
      sel_from_link <= 1'b0;
    end else begin
      WR_VALID <= 1'b0;
      proto_set <= 1'b0;
      wdata_set <= 1'b0;
      sel_from_link <= 1'b0;
      if (clk_rise) begin
        case (state_q)
          S_IDLE: begin
            // A low line is an idle cycle; a high bit opens a request.
            bit_cnt_q <= 6'h00;
            if (dio) begin // R1 R23
              state_q <= S_REQ;
            end
          end
          S_REQ: begin
            if (bit_cnt_q != `REQ_BITS) begin
              if (bit_cnt_q < 6'h05) begin
                req_q[bit_cnt_q[2:0]] <= dio; // R24 R4
              end
              if (bit_cnt_q == 6'h05) begin
                silent_q <= dio; // R8
              end
              bit_cnt_q <= bit_cnt_q + 6'h01;
            end else begin
              ap_q <= req_q[0]; // R2
              rnw_q <= req_q[1]; // R3
              a_q <= {req_q[3], req_q[2]}; // R4
              tsel_q <= ~req_q[0] & ~req_q[1] & ({req_q[3], req_q[2]} == `DP_A_TARGET_SELECTION_REGISTER);
              if (!req_frame_ok || silent_q) begin
                silent_q <= 1'b1;
                proto_set <= 1'b1;
              end else if (~req_q[0] & ~req_q[1] &
                           ({req_q[3], req_q[2]} == `DP_A_TARGET_SELECTION_REGISTER)) begin
                silent_q <= 1'b1; // R14
              end else begin
                silent_q <= 1'b0;
              end
              if (proto_err_q | wdata_err_q) begin
                ack_q <= `ACK_FAULT; // R10
              end else if (force_wait) begin
                ack_q <= `ACK_WAIT; // R10
              end else begin
                ack_q <= `ACK_OK; // R13
              end
              trn_cnt_q <= 2'h0;
              state_q <= S_TRN1;
            end
          end
          S_TRN1: begin
            trn_cnt_q <= trn_cnt_q + 2'h1;
            if (trn_cnt_q == trn_field) begin // R16 R22
              state_q <= S_ACK;
              bit_cnt_q <= 6'h00;
              SWDIO_OE <= ~silent_q;
              SWDIO_OUT <= ack_q[0]; // R10
            end
          end
          S_ACK: begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
            trn_cnt_q <= 2'h0;
            if (bit_cnt_q != 6'h02) begin
              SWDIO_OUT <= ack_q[bit_cnt_q[1:0] + 2'h1]; // R10
            end else if (!silent_q && ack_q == `ACK_OK && rnw_q) begin
              state_q <= S_RDAT;
              bit_cnt_q <= 6'h00;
              SWDIO_OUT <= read_data_q[0]; // R12
              rd_sh_q <= {^read_data_q, read_data_q[31:1]};
            end else if ((!silent_q && ack_q == `ACK_OK) || tsel_q) begin
              state_q <= S_TRN2; // R15
              SWDIO_OE <= 1'b0;
            end else begin
              state_q <= S_TRNE;
              SWDIO_OE <= 1'b0;
            end
          end
          S_RDAT: begin
            if (bit_cnt_q == `DATA_BITS) begin
              SWDIO_OE <= 1'b0;
              trn_cnt_q <= 2'h0;
              state_q <= S_TRNE;
            end else begin
              SWDIO_OUT <= rd_sh_q[0]; // R12
              rd_sh_q <= {1'b0, rd_sh_q[31:1]};
              bit_cnt_q <= bit_cnt_q + 6'h01;
            end
          end
          S_TRN2: begin
            trn_cnt_q <= trn_cnt_q + 2'h1;
            if (trn_cnt_q == trn_field) begin // R16 R17
              state_q <= S_WDAT;
              bit_cnt_q <= 6'h00;
            end
          end
          S_WDAT: begin
            if (bit_cnt_q != `DATA_BITS) begin
              bit_cnt_q <= bit_cnt_q + 6'h01;
            end else begin
              // The write lands only now, so its outcome shows in the next acknowledge.
              if (!tsel_q) begin
                if ((sh_par ^ dio) == 1'b0) begin // R21
                  WR_VALID <= 1'b1; // R18
                  WR_AP <= ap_q;
                  WR_ADDR <= dec_addr;
                  WR_DATA <= sh_data;
                  sel_from_link <= ~ap_q & (a_q == `DP_A_SELECT);
                end else begin
                  wdata_set <= 1'b1;
                end
              end
              state_q <= S_IDLE; // R19
            end
          end
          S_TRNE: begin
            trn_cnt_q <= trn_cnt_q + 2'h1;
            if (trn_cnt_q == trn_field) begin // R22
              state_q <= S_IDLE;
            end
          end
          default: begin
            state_q <= S_IDLE;
            SWDIO_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // APB slave answers with one wait state so that read data comes from a flip-flop.
  assign apb_acc = PSEL & PENABLE & PREADY;
  assign apb_wr = apb_acc & PWRITE;

  always @* begin
    rd_mux = 32'h0000_0000;
    map_ok = 1'b1;
    ro_reg = 1'b0;
    case (PADDR)
      `REG_LINK_CTRL: rd_mux = ctrl_q;
      `REG_SELECT: rd_mux = select_q;
      `REG_STATUS: rd_mux = {16'h0000, state_q, 6'h00, wdata_err_q, proto_err_q};
      `REG_READ_DATA: rd_mux = read_data_q;
      `REG_LAST_WDATA: begin
        rd_mux = WR_DATA;
        ro_reg = 1'b1;
      end
      `REG_LAST_WADDR: begin
        rd_mux = WR_ADDR;
        ro_reg = 1'b1;
      end
      default: map_ok = 1'b0;
    endcase
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      ctrl_q <= `CTRL_RST;
      select_q <= `SELECT_RST;
      read_data_q <= `READ_DATA_RST;
      proto_err_q <= 1'b0;
      wdata_err_q <= 1'b0;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      if (PSEL & PENABLE & ~PREADY) begin
        PSLVERR <= ~map_ok | (PWRITE & ro_reg);
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
      end else begin
        PSLVERR <= 1'b0;
      end
      if (apb_wr && PADDR == `REG_LINK_CTRL) begin
        ctrl_q <= {27'h000_0000, PWDATA[`CTRL_FORCE_WAIT], 2'h0,
                   PWDATA[`CTRL_TRN_HI:`CTRL_TRN_LO]};
      end
      if (apb_wr && PADDR == `REG_READ_DATA) begin
        read_data_q <= PWDATA;
      end
      // A link write to select beats a software write in the same cycle.
      if (sel_from_link) begin
        select_q <= WR_DATA; // R5 R6
      end else if (apb_wr && PADDR == `REG_SELECT) begin
        select_q <= PWDATA;
      end
      // Sticky flags clear on writing one; a new event in that cycle still sets.
      proto_err_q <= (proto_err_q &
        ~(apb_wr & (PADDR == `REG_STATUS) & PWDATA[`STAT_PROTO_ERR])) | proto_set;
      wdata_err_q <= (wdata_err_q &
        ~(apb_wr & (PADDR == `REG_STATUS) & PWDATA[`STAT_WDATA_ERR])) | wdata_set;
    end
  end
endmodule

// File: sim/swd_write_port_checker.sv
// Port-level assertions for the serial wire write port.
`timescale 1ns/100ps
module swd_write_port_checker #(
  parameter DATA_W = 32
) (
  input wire MCLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire SWDIO_OE,
  input wire WR_VALID,
  input wire WR_AP,
  input wire [31:0] WR_ADDR,
  input wire [DATA_W-1:0] WR_DATA
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  // One link bit is eight clocks, so a shorter span is always a fault.
  sequence driving;
    SWDIO_OE [*8];
  endsequence
  sequence released;
    !SWDIO_OE [*8];
  endsequence
  ack_drive_hold_a: assert property ($rose(SWDIO_OE) |-> driving)
    else $error("ack drive ended early");
  trn_release_a: assert property ($fell(SWDIO_OE) |-> released)
    else $error("line taken back in turnaround");
  write_pulse_a: assert property (WR_VALID |=> !WR_VALID)
    else $error("write strobe too long");
  write_quiet_a: assert property (WR_VALID |-> !SWDIO_OE)
    else $error("target drives at write end");
  write_hold_a: assert property ($changed({WR_AP, WR_ADDR, WR_DATA}) |-> WR_VALID)
    else $error("write outputs moved without strobe");
  dp_addr_a: assert property (WR_VALID && !WR_AP |-> WR_ADDR[31:8] == 24'h00_0000 &&
    WR_ADDR[3:2] != 2'h3) else $error("bad debug port address");
  word_align_a: assert property (WR_VALID |-> WR_ADDR[1:0] == 2'h0)
    else $error("address not word aligned");
  apb_wait_a: assert property (PSEL && $rose(PENABLE) |=> PREADY)
    else $error("ready not after one wait");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
endmodule
bind swd_write_port swd_write_port_checker #(.DATA_W(DATA_W)) chk (
  .MCLK(MCLK),
  .RST(RST),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PREADY(PREADY),
  .SWDIO_OE(SWDIO_OE),
  .WR_VALID(WR_VALID),
  .WR_AP(WR_AP),
  .WR_ADDR(WR_ADDR),
  .WR_DATA(WR_DATA)
);

// File: sim/swd_host_model.sv
// Behavioural debug host probe that clocks the link and sends writes.
`timescale 1ns/100ps
module swd_host_model (
  input wire mclk,
  input wire swdio_out,
  input wire swdio_oe,
  output logic swclk,
  output wire swdio
);
  logic drv_oe = 1'b1;
  logic drv_v = 1'b0;
  initial swclk = 1'b0;
  // A released line floats to the weak pull-up level.
  assign swdio = drv_oe ? drv_v : (swdio_oe ? swdio_out : 1'b1);
  // All link moves are non-blocking on the system clock, so they never race the
  // target's synchroniser; one link bit lasts eight system clocks.
  task automatic tick(input oe, input v, output s);
    drv_oe <= oe;
    drv_v <= v;
    repeat (4) @(posedge mclk);
    s = swdio;
    swclk <= 1'b1;
    repeat (4) @(posedge mclk);
    swclk <= 1'b0;
  endtask
  task automatic op(input ap, input direction_bit, input [1:0] a, input [31:0] d, input [1:0] bad,
                    input int trn, output [2:0] ack, output [32:0] rd);
    logic [7:0] req;
    logic s;
    req = {1'b1, 1'b0, ^{ap, direction_bit, a} ^ bad[0], a[1], a[0], direction_bit, ap, 1'b1};
    rd = 33'h0_0000_0000;
    for (int i = 0; i < 8; i++) tick(1'b1, req[i], s);
    for (int i = 0; i < trn; i++) tick(1'b0, 1'b0, s);
    for (int i = 0; i < 3; i++) begin
      tick(1'b0, 1'b0, s);
      ack[i] = s;
    end
    // Read data follows the acknowledge with no turnaround between them.
    if (direction_bit && ack == 3'h1) begin
      for (int i = 0; i < 33; i++) begin
        tick(1'b0, 1'b0, s);
        rd[i] = s;
      end
    end
    for (int i = 0; i < trn; i++) tick(1'b0, 1'b0, s);
    if (!direction_bit && (ack == 3'h1 || (!ap && a == 2'h3))) begin
      for (int i = 0; i < 32; i++) tick(1'b1, d[i], s);
      tick(1'b1, ^d ^ bad[1], s);
    end
    drv_oe <= 1'b1;
    drv_v <= 1'b0;
  endtask
endmodule

// File: sim/swd_write_port_tb.sv
// Self-checking bench for the serial wire write port.
`timescale 1ns/100ps
`include "swd_defs.vh"
`define CHK(n, e, g) begin num_checks++; if ((e) !== (g)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module swd_write_port_tb;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  wire [31:0] PRDATA, WR_ADDR, WR_DATA;
  wire PREADY, PSLVERR, SWCLK, SWDIO, SWDIO_OUT, SWDIO_OE, WR_VALID, WR_AP;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h0000_1e83;
  logic [31:0] sel = 32'h0000_0000;
  logic [31:0] rd;
  logic er;
  logic [2:0] ack;
  logic [32:0] rdw;
  logic [64:0] head;
  logic [64:0] expq[$];
  initial forever #10 MCLK = ~MCLK;
  swd_write_port dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SWCLK(SWCLK), .SWDIO_IN(SWDIO), .SWDIO_OUT(SWDIO_OUT),
    .SWDIO_OE(SWDIO_OE), .WR_VALID(WR_VALID), .WR_AP(WR_AP), .WR_ADDR(WR_ADDR),
    .WR_DATA(WR_DATA));
  swd_host_model host (.mclk(MCLK), .swdio_out(SWDIO_OUT), .swdio_oe(SWDIO_OE),
    .swclk(SWCLK), .swdio(SWDIO));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [32:0] with_par(input logic [31:0] x);
    return {^x, x};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input w, input [7:0] ad, input [31:0] wd, output [31:0] r, output e);
    int n;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      stop_test();
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input ap, input [1:0] a, input [31:0] d, input [1:0] bad, input int trn,
                    input [2:0] ea);
    // The strobe lands one clock after the host returns, inside the settle wait; the expectation goes in first.
    if (ea == `ACK_OK && !bad[1])
      expq.push_back(ap ? {1'b1, sel[31:4], a, 2'b00, d} :
        {1'b0, 24'h00_0000, (a == 2'h1) ? sel[3:0] : 4'h0, a, 2'b00, d});
    if (ea == `ACK_OK && !bad[1] && !ap && a == 2'h2) sel = d;
    host.op(ap, 1'b0, a, d, bad, trn, ack, rdw);
    // Let the strobe and any sticky flag settle before the next step looks at them.
    repeat (8) @(posedge MCLK);
    `CHK("ack", ea, ack)
  endtask
  // The word returned on the link is the read data register with its parity appended.
  task automatic rdl(input ap, input [1:0] a, input [31:0] d);
    apb(1'b1, `REG_READ_DATA, d, rd, er);
    host.op(ap, 1'b1, a, 32'h0000_0000, 2'b00, 1, ack, rdw);
    repeat (8) @(posedge MCLK);
    `CHK("read ack", `ACK_OK, ack)
    `CHK("read data", with_par(d), rdw)
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((expq.size() != 0 || n < 8) && n < 200) begin
      @(posedge MCLK);
      n++;
    end
    `CHK("pending writes", 0, expq.size())
  endtask
  always @(posedge MCLK) begin
    if (WR_VALID === 1'b1) begin
      if (expq.size() == 0) begin
        `CHK("surplus write", 1'b0, 1'b1)
      end else begin
        head = expq.pop_front();
        `CHK("write", head, {WR_AP, WR_ADDR, WR_DATA})
      end
    end
  end
  initial begin
    #1_000_000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    repeat (4) @(posedge MCLK);
    apb(1'b0, `REG_LINK_CTRL, 32'h0000_0000, rd, er);
    `CHK("ctrl reset", `CTRL_RST, rd)
    apb(1'b1, `REG_LAST_WDATA, 32'h0000_0001, rd, er);
    `CHK("read-only refusal", 1'b1, er)
    apb(1'b0, 8'hfc, 32'h0000_0000, rd, er);
    `CHK("unmapped refusal", 1'b1, er)
    seed = lfsr(seed);
    sel = seed;
    apb(1'b1, `REG_SELECT, sel, rd, er);
    apb(1'b0, `REG_SELECT, 32'h0000_0000, rd, er);
    `CHK("select", sel, rd)
    $display("registers done");
    wr(1'b0, 2'h1, 32'hffff_ffff, 2'b00, 1, `ACK_OK);
    wr(1'b1, 2'h3, 32'h0000_0000, 2'b00, 1, `ACK_OK);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(lfsr(seed));
      wr(seed[7], (!seed[7] && seed[9:8] == 2'h3) ? 2'h0 : seed[9:8], seed, 2'b00, 1, `ACK_OK);
    end
    drain();
    rdl(1'b0, 2'h0, seed ^ 32'h5a5a_a5a5);
    rdl(1'b1, seed[5:4], ~seed);
    $display("random writes done");
    wr(1'b0, 2'h3, seed, 2'b00, 1, 3'h7);
    wr(1'b1, 2'h2, seed, 2'b01, 1, 3'h7);
    apb(1'b0, `REG_STATUS, 32'h0000_0000, rd, er);
    `CHK("protocol flag", 1'b1, rd[`STAT_PROTO_ERR])
    wr(1'b1, 2'h2, seed, 2'b00, 1, `ACK_FAULT);
    apb(1'b1, `REG_STATUS, 32'h0000_0003, rd, er);
    wr(1'b1, 2'h0, seed, 2'b10, 1, `ACK_OK);
    apb(1'b0, `REG_STATUS, 32'h0000_0000, rd, er);
    `CHK("parity flag", 2'b10, rd[1:0])
    apb(1'b1, `REG_STATUS, 32'h0000_0003, rd, er);
    apb(1'b1, `REG_LINK_CTRL, 32'h0000_0010, rd, er);
    wr(1'b1, 2'h0, seed, 2'b00, 1, `ACK_WAIT);
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, `REG_LINK_CTRL, t, rd, er);
      wr(1'b0, 2'h0, seed ^ t, 2'b00, t + 1, `ACK_OK);
    end
    drain();
    $display("error and turnaround cases done");
    stop_test();
  end
endmodule
